// ---- masc_pkg.sv ----
package masc_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [4:0] IDX_BASIC_MODE_CONTROL      = 5'h00;
  localparam logic [4:0] IDX_ABILITY_ADVERTISEMENT   = 5'h04;
  localparam logic [4:0] IDX_CODING_SUBLAYER_CONTROL = 5'h16;
  localparam logic [4:0] IDX_LINK_CLOCK_CONTROL      = 5'h17;
  localparam logic [4:0] IDX_CONFIG_STATUS           = 5'h18;

  // Basic mode control fields
  localparam int BMC_RESTART_BIT = 9;
  localparam int BMC_DUPLEX_BIT  = 8;
  localparam int BMC_NEGOTIATION_ENABLE_STRAP_BIT   = 12;
  localparam int BMC_SPEED_BIT   = 13;

  // Coding sublayer control fields
  localparam int CSC_FIBER_BIT   = 6;
  localparam int CSC_FEF_BIT     = 3;
  localparam int CSC_SCR_BIT     = 1;
  localparam int CSC_DESCR_BIT   = 0;

  // Link clock control and configuration status fields
  localparam int LCC_MASTER_BIT  = 0;
  localparam int CST_STRAP_LSB   = 0;
  localparam int CST_LOADED_BIT  = 4;
  localparam int CST_VALID_BIT   = 5;
  localparam int CST_SPEED_BIT   = 6;
  localparam int CST_DUPLEX_BIT  = 7;

  // Advertisement layout: ability bits [8:5], selector [4:0]
  localparam int ADV_LSB = 5;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  // Ability order {100 full, 100 half, 10 full, 10 half}
  localparam logic [3:0] ADV_10_BOTH  = 4'h3;
  localparam logic [3:0] ADV_100_BOTH = 4'hC;
  localparam logic [3:0] ADV_100_FULL = 4'h8;
  localparam logic [3:0] ADV_ALL      = 4'hF;

  // Strap vector positions and settle time
  localparam int STRAP_MEDIA = 3;
  localparam int STRAP_NEGOTIATION_ENABLE_STRAP = 2;
  localparam int STRAP_AN1   = 1;
  localparam int STRAP_AN0   = 0;
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

  // Timing figures, in bit times unless marked
  localparam int REF_CLK_PERIOD_NS = 40;
  localparam logic [7:0] TX_LATENCY_BITS     = 8'h0D; // 13
  localparam logic [7:0] RX_LATENCY_TP_BITS  = 8'h38; // 56
  localparam logic [7:0] RX_LATENCY_FX_BITS  = 8'h2E; // 46
  localparam logic [7:0] CRS_ON_TP_BITS      = 8'h13; // 19
  localparam logic [7:0] CRS_ON_FX_BITS      = 8'h09; // 9
  localparam logic [7:0] CRS_OFF_TP_BITS     = 8'h1A; // 26
  localparam logic [7:0] CRS_OFF_FX_BITS     = 8'h10; // 16
  localparam logic [1:0] ELASTICITY_DEFAULT  = 2'h1;

  typedef struct packed {
    logic       fiber;
    logic       anEnable;
    logic       speed100;
    logic       fullDuplex;
    logic [3:0] advertise;
  } masc_link_cfg_t;

  typedef struct packed {
    logic [7:0] txBits;
    logic [7:0] rxBits;
    logic [7:0] crsOnBits;
    logic [7:0] crsOffBits;
  } masc_latency_t;

  typedef struct packed {
    logic [3:0] data;
    logic       valid;
    logic       error;
  } masc_mii_rx_t;

  typedef struct packed {
    logic [3:0] data;
    logic       enable;
  } masc_mii_tx_t;

  typedef struct packed {
    logic       valid;
    logic       speed100;
    logic       fullDuplex;
  } masc_resolved_t;

endpackage

// ---- masc_config.sv ----
`timescale 1ns/10ps
`default_nettype none
module masc_config
  import masc_pkg::*;
(
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  // Strap pins
  input  wire logic           rxErrorStrap,
  input  wire logic           negotiation_enable_strap,
  input  wire logic           ability_strap_high,
  input  wire logic           ability_strap_low,
  // Avalon-MM slave
  input  wire logic [6:0]     avsAddress,
  input  wire logic           avsRead,
  input  wire logic           avsWrite,
  input  wire logic [3:0]     avsByteenable,
  input  wire logic [31:0]    avsWritedata,
  output logic      [31:0]    avsReaddata,
  output logic                avsWaitrequest,
  // Negotiation partner ability {100F,100H,10F,10H}
  input  wire logic [3:0]     partnerAbility,
  // Single-clock MAC path
  input  wire masc_mii_tx_t   txFromMac,
  input  wire masc_mii_rx_t   rxFromPcs,
  input  wire logic           crsFromPcs,
  output masc_mii_tx_t        txCaptured,
  output masc_mii_rx_t        rxToMac,
  output logic                crsToMac,
  // Configuration results
  output masc_link_cfg_t      linkCfg,
  output masc_resolved_t      resolvedMode,
  output masc_latency_t       latency,
  output logic                restartNegotiation,
  output logic                rmiiClkOut
);

  // Whole state of the block
  typedef struct packed {
    logic [3:0]     sy1;
    logic [3:0]     sy2;
    logic [3:0]     sy3;
    logic [3:0]     filt;
    logic [2:0]     settle;
    logic           loaded;
    logic [3:0]     strapCap;
    masc_link_cfg_t cfg;
    logic           farEnd;
    logic           scrBypass;
    logic           descrBypass;
    logic           restart;
    logic           rmiiMaster;
    logic           rmiiClk;
    logic           ack;
    logic [15:0]    rdData;
    masc_resolved_t res;
    masc_latency_t  lat;
    masc_mii_tx_t   tx;
    masc_mii_rx_t   rx;
  } masc_state_t;

  masc_state_t state_reg;
  masc_state_t state_next;

  logic        reqActive;
  logic        wrAccept;
  logic [4:0]  regIndex;
  logic [15:0] wrOld;
  logic [15:0] wrVal;

  // Advertised set for an ability strap pair
  function automatic logic [3:0] advFromStrap(input logic [1:0] ab);
    unique case (ab)
      2'b00:   advFromStrap = ADV_10_BOTH;
      2'b01:   advFromStrap = ADV_100_BOTH;
      2'b10:   advFromStrap = ADV_100_FULL;
      2'b11:   advFromStrap = ADV_ALL;
    endcase
  endfunction

  // Highest common mode, priority 100F > 100H > 10F > 10H
  function automatic masc_resolved_t bestMode(input logic [3:0] common);
    bestMode = '0;
    if (common[3])
      bestMode = '{valid: 1'b1, speed100: 1'b1, fullDuplex: 1'b1};
    else if (common[2])
      bestMode = '{valid: 1'b1, speed100: 1'b1, fullDuplex: 1'b0};
    else if (common[1])
      bestMode = '{valid: 1'b1, speed100: 1'b0, fullDuplex: 1'b1};
    else if (common[0])
      bestMode = '{valid: 1'b1, speed100: 1'b0, fullDuplex: 1'b0};
  endfunction

  // Register read image by index
  function automatic logic [15:0] regRead(input logic [4:0] idx,
                                          input masc_state_t s);
    regRead = '0;
    unique case (idx)
      IDX_BASIC_MODE_CONTROL:
      begin
        regRead[BMC_SPEED_BIT]   = s.cfg.speed100;
        regRead[BMC_NEGOTIATION_ENABLE_STRAP_BIT]   = s.cfg.anEnable;
        regRead[BMC_RESTART_BIT] = s.restart;
        regRead[BMC_DUPLEX_BIT]  = s.cfg.fullDuplex;
      end
      IDX_ABILITY_ADVERTISEMENT:
      begin
        regRead[ADV_LSB +: 4] = s.cfg.advertise;
        regRead[4:0]          = ADV_SELECTOR;
      end
      IDX_CODING_SUBLAYER_CONTROL:
      begin
        regRead[CSC_FIBER_BIT] = s.cfg.fiber;
        regRead[CSC_FEF_BIT]   = s.farEnd;
        regRead[CSC_SCR_BIT]   = s.scrBypass;
        regRead[CSC_DESCR_BIT] = s.descrBypass;
      end
      IDX_LINK_CLOCK_CONTROL:
        regRead[LCC_MASTER_BIT] = s.rmiiMaster;
      IDX_CONFIG_STATUS:
      begin
        regRead[CST_STRAP_LSB +: 4] = s.strapCap;
        regRead[CST_LOADED_BIT]     = s.loaded;
        regRead[CST_VALID_BIT]      = s.res.valid;
        regRead[CST_SPEED_BIT]      = s.res.speed100;
        regRead[CST_DUPLEX_BIT]     = s.res.fullDuplex;
      end
      default:
        regRead = '0;
    endcase
  endfunction

  // Bus handshake: one wait cycle, then the request is taken
  assign reqActive      = avsRead | avsWrite;
  assign avsWaitrequest = reqActive & ~state_reg.ack;
  assign wrAccept       = avsWrite & state_reg.ack;
  assign regIndex       = avsAddress[6:2];
  assign wrOld          = regRead(regIndex, state_reg);
  assign wrVal          = {avsByteenable[1] ? avsWritedata[15:8] : wrOld[15:8],
                           avsByteenable[0] ? avsWritedata[7:0] : wrOld[7:0]};

  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    // Strap pins pass three flops; a change counts when stages agree
    state_next.sy1 = {rxErrorStrap, negotiation_enable_strap,
                      ability_strap_high, ability_strap_low};
    state_next.sy2 = state_reg.sy1;
    state_next.sy3 = state_reg.sy2;
    for (int i = 0; i < 4; i++)
    begin
      if (state_reg.sy2[i] == state_reg.sy3[i])
        state_next.filt[i] = state_reg.sy3[i];
    end
    state_next.restart = 1'b0;
    // Capture straps once after reset release
    if (!state_reg.loaded)
    begin
      if (state_reg.settle != STRAP_SETTLE_CYCLES)
        state_next.settle = state_reg.settle + 3'h1;
      else
      begin
        state_next.loaded   = 1'b1;
        state_next.strapCap = state_reg.filt;
        // Pulled low means fiber, floating high twisted pair
        state_next.cfg.fiber = ~state_reg.filt[STRAP_MEDIA];
        // Fiber strap presets the coding control bits
        state_next.farEnd      = ~state_reg.filt[STRAP_MEDIA];
        state_next.scrBypass   = ~state_reg.filt[STRAP_MEDIA];
        state_next.descrBypass = ~state_reg.filt[STRAP_MEDIA];
        // Negotiation set up by pins with no register access
        state_next.cfg.anEnable   = state_reg.filt[STRAP_NEGOTIATION_ENABLE_STRAP];
        // Forced mode from ability straps when negotiation off
        state_next.cfg.speed100   = state_reg.filt[STRAP_AN1];
        state_next.cfg.fullDuplex = state_reg.filt[STRAP_AN0];
        // Advertised abilities loaded from straps, all four if negotiation strapped off
        state_next.cfg.advertise  = state_reg.filt[STRAP_NEGOTIATION_ENABLE_STRAP] ?
          advFromStrap(state_reg.filt[STRAP_AN1:STRAP_AN0]) : ADV_ALL;
      end
    end
    // Read data latched in the wait cycle
    state_next.ack = reqActive & ~state_reg.ack;
    if (reqActive && !state_reg.ack)
      state_next.rdData = avsRead ? regRead(regIndex, state_reg) : 16'h0000;
    // Register writes take effect at the accepting edge
    if (wrAccept && state_reg.loaded)
    begin
      unique case (regIndex)
        IDX_BASIC_MODE_CONTROL:
        begin
          state_next.cfg.speed100   = wrVal[BMC_SPEED_BIT];
          state_next.cfg.fullDuplex = wrVal[BMC_DUPLEX_BIT];
          state_next.cfg.anEnable   = wrVal[BMC_NEGOTIATION_ENABLE_STRAP_BIT];
          // Restart on request or when negotiation is newly enabled
          state_next.restart = wrVal[BMC_RESTART_BIT] |
            (wrVal[BMC_NEGOTIATION_ENABLE_STRAP_BIT] & ~state_reg.cfg.anEnable);
        end
        IDX_ABILITY_ADVERTISEMENT:
          state_next.cfg.advertise = wrVal[ADV_LSB +: 4];
        IDX_CODING_SUBLAYER_CONTROL:
        begin
          state_next.cfg.fiber   = wrVal[CSC_FIBER_BIT];
          state_next.farEnd      = wrVal[CSC_FEF_BIT];
          state_next.scrBypass   = wrVal[CSC_SCR_BIT];
          state_next.descrBypass = wrVal[CSC_DESCR_BIT];
        end
        IDX_LINK_CLOCK_CONTROL:
          state_next.rmiiMaster = wrVal[LCC_MASTER_BIT];
        default:
          state_next.rmiiMaster = state_reg.rmiiMaster;
      endcase
    end
    // Mode resolution against the partner
    if (state_reg.cfg.anEnable)
      state_next.res = bestMode(state_reg.cfg.advertise & partnerAbility);
    else
      state_next.res = '{valid: 1'b1, speed100: state_reg.cfg.speed100,
                         fullDuplex: state_reg.cfg.fullDuplex};
    // Receive and carrier sense latency figures follow the media, transmit fixed
    state_next.lat.txBits     = TX_LATENCY_BITS;
    state_next.lat.rxBits     = state_reg.cfg.fiber ?
                                RX_LATENCY_FX_BITS : RX_LATENCY_TP_BITS;
    state_next.lat.crsOnBits  = state_reg.cfg.fiber ?
                                CRS_ON_FX_BITS : CRS_ON_TP_BITS;
    state_next.lat.crsOffBits = state_reg.cfg.fiber ?
                                CRS_OFF_FX_BITS : CRS_OFF_TP_BITS;
    // Interface clock generated by division in master mode
    state_next.rmiiClk = state_reg.rmiiMaster & ~state_reg.rmiiClk;
    // Transmit captured, receive launched on the rising edge
    state_next.tx = txFromMac;
    state_next.rx = rxFromPcs;
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // Outputs
  assign avsReaddata        = {16'h0000, state_reg.rdData};
  assign linkCfg            = state_reg.cfg;
  assign resolvedMode       = state_reg.res;
  assign latency            = state_reg.lat;
  assign restartNegotiation = state_reg.restart;
  assign rmiiClkOut         = state_reg.rmiiClk;
  assign txCaptured         = state_reg.tx;
  assign rxToMac            = state_reg.rx;
  // Carrier sense passes straight through, not tied to edges
  assign crsToMac           = crsFromPcs;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_strap_media_pick: assert property (
    $rose(state_reg.loaded) |->
      linkCfg.fiber == ~state_reg.strapCap[STRAP_MEDIA])
    else $error("media does not follow the strap");

  a_fiber_preset_bits: assert property (
    $rose(state_reg.loaded) && linkCfg.fiber |->
      state_reg.farEnd && state_reg.scrBypass && state_reg.descrBypass)
    else $error("fiber strap did not preset coding bits");

  a_fiber_write_takes: assert property (
    wrAccept && state_reg.loaded &&
      regIndex == IDX_CODING_SUBLAYER_CONTROL && avsByteenable[0] |=>
      linkCfg.fiber == $past(avsWritedata[CSC_FIBER_BIT]))
    else $error("fiber select write lost");

  a_forced_mode_load: assert property (
    $rose(state_reg.loaded) && !state_reg.strapCap[STRAP_NEGOTIATION_ENABLE_STRAP] |->
      !linkCfg.anEnable &&
      linkCfg.speed100 == state_reg.strapCap[STRAP_AN1] &&
      linkCfg.fullDuplex == state_reg.strapCap[STRAP_AN0])
    else $error("forced mode wrong");

  a_advert_load: assert property (
    $rose(state_reg.loaded) && state_reg.strapCap[STRAP_NEGOTIATION_ENABLE_STRAP] |->
      linkCfg.advertise ==
      advFromStrap(state_reg.strapCap[STRAP_AN1:STRAP_AN0]))
    else $error("advertisement not loaded from straps");

  a_control_write: assert property (
    wrAccept && state_reg.loaded &&
      regIndex == IDX_BASIC_MODE_CONTROL && avsByteenable[1] |=>
      linkCfg.anEnable == $past(avsWritedata[BMC_NEGOTIATION_ENABLE_STRAP_BIT]) &&
      linkCfg.speed100 == $past(avsWritedata[BMC_SPEED_BIT]))
    else $error("control write not honoured");

  a_best_mode: assert property (
    linkCfg.anEnable && (linkCfg.advertise[3] & partnerAbility[3]) |=>
      resolvedMode.valid && resolvedMode.speed100 && resolvedMode.fullDuplex)
    else $error("best common mode not chosen");

  a_rx_launch: assert property (
    ##1 rxToMac == $past(rxFromPcs))
    else $error("receive outputs not launched from the edge");

  a_straps_once: assert property (
    state_reg.loaded && !wrAccept |=> $stable(linkCfg.fiber))
    else $error("media changed without a write");

  a_wait_one: assert property (
    reqActive && avsWaitrequest |=> !avsWaitrequest)
    else $error("wait request longer than one cycle");

  a_rx_latency: assert property (
    state_reg.loaded |=> latency.rxBits ==
      ($past(linkCfg.fiber) ? RX_LATENCY_FX_BITS : RX_LATENCY_TP_BITS))
    else $error("receive latency does not follow the media");

  a_crs_latency: assert property (
    state_reg.loaded && linkCfg.fiber |=>
      latency.crsOnBits == CRS_ON_FX_BITS &&
      latency.crsOffBits == CRS_OFF_FX_BITS)
    else $error("carrier sense delays do not follow the media");

  a_tx_latency: assert property (
    state_reg.loaded |-> latency.txBits == TX_LATENCY_BITS)
    else $error("transmit latency figure wrong");

  a_negotiate_set: assert property (
    $rose(state_reg.loaded) |->
      linkCfg.anEnable == state_reg.strapCap[STRAP_NEGOTIATION_ENABLE_STRAP])
    else $error("negotiation enable does not follow the strap");

  a_restart_pulse: assert property (
    restartNegotiation |=> !restartNegotiation)
    else $error("restart pulse longer than one cycle");

  a_clock_divide: assert property (
    rmiiClkOut || !state_reg.rmiiMaster |=> !rmiiClkOut)
    else $error("interface clock does not divide by two");

  a_crs_direct: assert property (
    crsToMac == crsFromPcs)
    else $error("carrier sense not passed straight through");

  c_fiber_strap: cover property ($rose(state_reg.loaded) && linkCfg.fiber);
  c_forced_mode: cover property ($rose(state_reg.loaded) && !linkCfg.anEnable);
  c_fiber_write: cover property (wrAccept &&
                                 regIndex == IDX_CODING_SUBLAYER_CONTROL);
  c_best_100f:   cover property (resolvedMode.valid && linkCfg.anEnable &&
                                 resolvedMode.speed100 &&
                                 resolvedMode.fullDuplex);
  c_restart:     cover property (restartNegotiation);

endmodule // masc_config
`default_nettype wire

// ---- masc_strap_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module masc_strap_model (
  // Board fitting: {media pulldown, negotiate, ability high, ability low}
  input  wire logic [3:0] fitting,
  // Strap pins
  output logic            rxErrorStrap,
  output logic            negotiation_enable_strap,
  output logic            ability_strap_high,
  output logic            ability_strap_low
);
  // A fitted pulldown pulls the media strap low, otherwise it floats high
  assign rxErrorStrap = ~fitting[3];
  // Negotiation straps come from resistors alone, no host involved
  assign negotiation_enable_strap = fitting[2];
  assign ability_strap_high       = fitting[1];
  assign ability_strap_low        = fitting[0];
endmodule // masc_strap_model
`default_nettype wire

// ---- masc_config_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module masc_config_tb
  import masc_pkg::*;
;
  typedef struct packed {
    logic [3:0] fit;
    logic [3:0] adv;
  } masc_row_t;

  // Clock, reset, straps
  logic           core_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic [3:0]     fitting = 4'h0;
  logic           rxErrorStrap, anStrap, abHigh, abLow;
  // Register bus
  logic [6:0]     avsAddress = 7'h00;
  logic           avsRead = 1'b0;
  logic           avsWrite = 1'b0;
  logic [3:0]     avsByteenable = 4'h3;
  logic [31:0]    avsWritedata = 32'h0;
  logic [31:0]    avsReaddata;
  logic           avsWaitrequest;
  // Link side
  logic [3:0]     partnerAbility = 4'hF;
  masc_mii_tx_t   txFromMac = '0;
  masc_mii_rx_t   rxFromPcs = '0;
  logic           crsFromPcs = 1'b0;
  masc_mii_tx_t   txCaptured;
  masc_mii_rx_t   rxToMac;
  logic           crsToMac, restartNegotiation, rmiiClkOut, prevClk;
  masc_link_cfg_t linkCfg;
  masc_resolved_t resolvedMode;
  masc_latency_t  latency;
  // Bench bookkeeping
  int             error_cnt = 0;
  int             compares = 0;
  int             pulses = 0;
  int             p0;
  logic [15:0]    rd;
  logic [3:0]     pm [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h3, 4'hA,
                             4'h0};
  masc_row_t      rows [8] = '{8'h0F, 8'h9F, 8'h2F, 8'hBF,
                               8'h43, 8'hDC, 8'h68, 8'hFF};

  // Clock and restart pulse counter
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (restartNegotiation === 1'b1)
      pulses <= pulses + 1;

  // Board straps and device
  masc_strap_model straps (.fitting(fitting), .rxErrorStrap(rxErrorStrap),
    .negotiation_enable_strap(anStrap), .ability_strap_high(abHigh),
    .ability_strap_low(abLow));
  masc_config dut (.core_clk(core_clk), .rst_n(rst_n),
    .rxErrorStrap(rxErrorStrap), .negotiation_enable_strap(anStrap),
    .ability_strap_high(abHigh), .ability_strap_low(abLow),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsByteenable(avsByteenable), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .partnerAbility(partnerAbility), .txFromMac(txFromMac),
    .rxFromPcs(rxFromPcs), .crsFromPcs(crsFromPcs),
    .txCaptured(txCaptured), .rxToMac(rxToMac), .crsToMac(crsToMac),
    .linkCfg(linkCfg), .resolvedMode(resolvedMode), .latency(latency),
    .restartNegotiation(restartNegotiation), .rmiiClkOut(rmiiClkOut));

  // Verdict and end of run
  task automatic final_report();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic give_up();
    error_cnt++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report();
  endtask

  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] idx,
                     input logic [15:0] wd);
    int n;
    @(posedge core_clk);
    avsAddress   <= {idx, 2'b00};
    avsWrite     <= wr;
    avsRead      <= ~wr;
    avsWritedata <= {16'h0000, wd};
    for (n = 0; n < 16; n++)
    begin
      // Waitrequest as it stood at this rising edge
      @(posedge core_clk);
      if (avsWaitrequest === 1'b0)
        break;
    end
    if (n == 16)
      give_up();
    // Data taken and request released at the accepting edge
    rd = avsReaddata[15:0];
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
  endtask

  // Reset with new straps, then poll until they are loaded
  task automatic restrap(input logic [3:0] fit);
    int n;
    @(posedge core_clk);
    rst_n   <= 1'b0;
    fitting <= fit;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      bus(1'b0, IDX_CONFIG_STATUS, 16'h0);
      if (rd[CST_LOADED_BIT] === 1'b1)
        break;
    end
    if (n == 20)
      give_up();
  endtask

  // Best mode common to both ends, as {valid, speed100, full}
  function automatic logic [2:0] best(input logic [3:0] m);
    if (m[3]) return 3'b111;
    if (m[2]) return 3'b110;
    if (m[1]) return 3'b101;
    if (m[0]) return 3'b100;
    return 3'b000;
  endfunction

  function automatic logic [31:0] lat(input logic fx);
    return fx ? {TX_LATENCY_BITS, RX_LATENCY_FX_BITS, CRS_ON_FX_BITS,
                 CRS_OFF_FX_BITS}
              : {TX_LATENCY_BITS, RX_LATENCY_TP_BITS, CRS_ON_TP_BITS,
                 CRS_OFF_TP_BITS};
  endfunction

  // Main sequence: strap table, then hand-written cases
  initial
  begin
    repeat (19) @(posedge core_clk);
    check(32'(linkCfg), 32'h0);
    @(posedge core_clk);
    foreach (rows[i])
    begin
      restrap(rows[i].fit);
      check(32'(linkCfg), 32'(rows[i]));
      bus(1'b0, IDX_ABILITY_ADVERTISEMENT, 16'h0);
      check(32'(rd), 32'({rows[i].adv, ADV_SELECTOR}));
      bus(1'b0, IDX_CODING_SUBLAYER_CONTROL, 16'h0);
      check(32'(rd), rows[i].fit[3] ? 32'h4B : 32'h0);
      bus(1'b0, IDX_BASIC_MODE_CONTROL, 16'h0);
      check(32'(rd), 32'({2'b00, rows[i].fit[1], rows[i].fit[2], 3'h0,
            rows[i].fit[0], 8'h00}));
      check(32'(resolvedMode), 32'(rows[i].fit[2] ? best(rows[i].adv)
            : {1'b1, rows[i].fit[1:0]}));
      check(32'(latency), lat(rows[i].fit[3]));
    end
    // Strap changes after loading are ignored
    @(posedge core_clk);
    fitting <= 4'h0;
    repeat (10) @(posedge core_clk);
    check(32'(linkCfg), 32'hFF);
    // Media select by host write, both directions
    bus(1'b1, IDX_CODING_SUBLAYER_CONTROL, 16'h0);
    repeat (2) @(negedge core_clk);
    check(32'(linkCfg.fiber), 32'h0);
    check(32'(latency), lat(1'b0));
    bus(1'b1, IDX_CODING_SUBLAYER_CONTROL, 16'h0040);
    repeat (2) @(negedge core_clk);
    check(32'(linkCfg.fiber), 32'h1);
    check(32'(latency), lat(1'b1));
    // Host forces 10 full, then re-enables and restarts negotiation
    p0 = pulses;
    bus(1'b1, IDX_BASIC_MODE_CONTROL, 16'h0100);
    repeat (2) @(negedge core_clk);
    check(32'({linkCfg[6:4], resolvedMode}), 32'h0D);
    check(32'(pulses - p0), 32'h0);
    bus(1'b1, IDX_BASIC_MODE_CONTROL, 16'h1000);
    repeat (3) @(posedge core_clk);
    check(32'(pulses - p0), 32'h1);
    bus(1'b1, IDX_BASIC_MODE_CONTROL, 16'h1200);
    repeat (3) @(posedge core_clk);
    check(32'(pulses - p0), 32'h2);
    bus(1'b0, IDX_BASIC_MODE_CONTROL, 16'h0);
    check(32'(rd), 32'h1000);
    // Low lane only: control bits in the high lane must stay
    @(posedge core_clk);
    avsByteenable <= 4'h1;
    bus(1'b1, IDX_BASIC_MODE_CONTROL, 16'hFFFF);
    avsByteenable <= 4'h3;
    bus(1'b0, IDX_BASIC_MODE_CONTROL, 16'h0);
    check(32'(rd), 32'h1000);
    check(32'(pulses - p0), 32'h2);
    // Resolution against each partner set, then a narrowed advertisement
    foreach (pm[i])
    begin
      @(posedge core_clk);
      partnerAbility <= pm[i];
      repeat (2) @(negedge core_clk);
      check(32'(resolvedMode), 32'(best(pm[i])));
    end
    bus(1'b1, IDX_ABILITY_ADVERTISEMENT, {7'h00, 4'h3, ADV_SELECTOR});
    @(posedge core_clk);
    partnerAbility <= 4'hF;
    repeat (2) @(negedge core_clk);
    check(32'(resolvedMode), 32'h5);
    // MAC path: registered nibbles, carrier sense passed straight through
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      txFromMac  <= {4'(k * 5), 1'b1};
      rxFromPcs  <= {4'(~(k * 3)), 1'b1, k[0]};
      crsFromPcs <= k[1];
      @(negedge core_clk);
      check(32'(crsToMac), 32'(k[1]));
      @(negedge core_clk);
      check(32'(txCaptured), 32'({4'(k * 5), 1'b1}));
      check(32'(rxToMac), 32'({4'(~(k * 3)), 1'b1, k[0]}));
    end
    // Interface clock generation on and off
    bus(1'b1, IDX_LINK_CLOCK_CONTROL, 16'h0001);
    repeat (2) @(negedge core_clk);
    prevClk = rmiiClkOut;
    @(negedge core_clk);
    check(32'(rmiiClkOut ^ prevClk), 32'h1);
    bus(1'b1, IDX_LINK_CLOCK_CONTROL, 16'h0000);
    repeat (2) @(negedge core_clk);
    check(32'(rmiiClkOut), 32'h0);
    // Unmapped index reads zero
    bus(1'b0, 5'h1F, 16'h0);
    check(32'(rd), 32'h0);
    final_report();
  end
endmodule // masc_config_tb
`default_nettype wire
